// ===== asrp_consts.vh
// Constants for the converter serial result port: register map, fields, timing
`ifndef ASRP_CONSTS_VH
`define ASRP_CONSTS_VH

// Register byte offsets on the bus
`define ASRP_CTRL_OFS       8'h00
`define ASRP_RESULT_OFS     8'h04
`define ASRP_CONV_OFS       8'h08
`define ASRP_STATUS_OFS     8'h0c

// Control register field positions
`define ASRP_CTRL_SERIAL    0
`define ASRP_CTRL_CLKSRC    1
`define ASRP_CTRL_RDTIME    2
`define ASRP_CTRL_EDGEINV   3
`define ASRP_CTRL_SYNCINV   4
`define ASRP_CTRL_FORMAT    5
`define ASRP_CTRL_WIDTH     6
`define ASRP_CTRL_RESET     6'h00

// Result word and frame length
`define ASRP_WORD_BITS      16
`define ASRP_RESULT_RESET   16'h0000

// Master clock: one serial period in system cycles, and its high window
`define ASRP_SYS_PERIOD_NS  5
`define ASRP_SCLK_PERIOD_NS 40
`define ASRP_SCLK_CYCLES    (`ASRP_SCLK_PERIOD_NS / `ASRP_SYS_PERIOD_NS)
`define ASRP_SCLK_RISE      3'h2
`define ASRP_SCLK_FALL      3'h6

// Last phase of a period, last bit of a frame, full frame count
`define ASRP_PHASE_LAST     3'h7
`define ASRP_BIT_LAST       5'h0f
`define ASRP_BIT_FULL       5'h10

`endif

// ===== asrp_serial_result_port.v
// Serial result port of a sampling converter with an AHB-Lite register slave
//
// Behaviour
// - Read timing select matters only in master serial
// - Low select: send current result after conversion
// - Read after conversion lengthens each conversion cycle
// - High select: send previous result during conversion
// - Slave mode accepts chained serial input stream
// - Chained input follows own word, sixteen periods late
// - Shared data pin carries serial result output
// - Result held, shifted out MSB first
// - Format select picks offset binary or two's complement
// - Master data stable across both clock edges
// - Slave, invert low: change on rising edge
// - Slave, invert high: change on falling edge
// - Clock pin direction set by clock source select
// - Source low: device master; high: host drives
// - Parallel mode: shared pins carry bits 8-10
// - Master mode drives frame sync output
// - Sync polarity set by sync invert bit
// - Frame sync held for all valid bits
//
// Register map, one aligned word each
// 0x00 control: mode, clock source, timing, edge, sync, format
// 0x04 result: write ends a conversion, queues the word
// 0x08 start: write bit 0 high to begin a conversion
// 0x0c status: full, converting, frame busy, buffer level
//
// Control bits
// Bit 0 set: serial pins; clear: parallel bits 8 to 10
// Bit 1 set: host drives clock; clear: device drives it
// Bit 2 set: read during conversion; clear: after it
// Bit 3 set: inverted clock edge
// Bit 4 set: frame sync active low
// Bit 5 set: offset binary; clear: two's complement
//
// Bus timing
// One data phase cycle for every access but one
// Result write into a full buffer waits for a free entry
// Read data taken from the address phase state
// Unmapped reads give zero, unmapped writes are dropped
//
// Master timing
// Eight system cycles per serial period
// Clock pin high for phases three to six
// Data pin moves just after phase zero
// So every bit stands across both clock edges
// Frame sync spans all sixteen periods
//
// Slave timing
// Clock, select and chain pins pass two flops first
// Three to four cycles from pin edge to data pin
// Host clock must stay far below the system clock
// Empty buffer at frame start resends the held word
//
// Hazards
// Parallel mode never drains the buffer
// A third queued result write then stalls the bus
// Mode changes are only safe between frames
`timescale 1ns/100ps
`include "asrp_consts.vh"

module asrp_serial_result_port (
   input  wire        clock,                 // System clock, 200 MHz
   input  wire        rst_b,                 // Synchronous reset, active low
   input  wire        hsel,                  // Slave select
   input  wire [31:0] haddr,                 // Byte address
   input  wire [1:0]  htrans,                // Transfer type
   input  wire        hwrite,                // Write when high
   input  wire [2:0]  hsize,                 // Transfer size
   input  wire [31:0] hwdata,                // Write data
   input  wire        hready,                // Bus ready
   output reg         hreadyout,             // Slave ready
   output reg  [31:0] hrdata,                // Read data
   output reg         hresp,                 // Always OKAY
   input  wire        serial_data_clock_in,  // Clock pin level from host
   input  wire        chip_select_b,         // Slave frame gate, active low
   input  wire        chain_serial_input,    // Daisy chain input
   output reg         serial_result_out,     // Shared data pin
   output reg         serial_data_clock_out, // Clock pin drive level
   output reg         serial_data_clock_oe_b,// Clock pin enable, low drives
   output reg         frame_sync_out         // Shared frame sync pin
);

   // Control fields decoded from the control register
   reg  [`ASRP_CTRL_WIDTH-1:0] ctrl;          // Control register
   wire serial_parallel_select = ctrl[`ASRP_CTRL_SERIAL];
   wire clock_source_select    = ctrl[`ASRP_CTRL_CLKSRC];
   wire read_timing_select     = ctrl[`ASRP_CTRL_RDTIME];
   wire clock_edge_invert      = ctrl[`ASRP_CTRL_EDGEINV];
   wire frame_polarity_invert  = ctrl[`ASRP_CTRL_SYNCINV];
   wire output_format_select   = ctrl[`ASRP_CTRL_FORMAT];
   wire master_mode = serial_parallel_select & ~clock_source_select;
   wire slave_mode  = serial_parallel_select &  clock_source_select;

   // Bus pipeline state
   reg         dp_write;                      // Write in data phase
   reg  [7:0]  dp_addr;                       // Offset of data phase
   reg  [15:0] held_result;                   // Last result written
   reg         converting;                    // Conversion in progress
   reg         conv_start;                    // One-cycle start event

   // Two-entry result buffer
   reg  [15:0] buf_mem [0:1];                 // Storage
   reg         buf_wr;                        // Write pointer
   reg         buf_rd;                        // Read pointer
   reg  [1:0]  buf_cnt;                       // Fill level
   wire        buf_valid = (buf_cnt != 2'h0); // Drain side valid
   wire        buf_full  = (buf_cnt == 2'h2); // Fill side not ready
   wire        buf_push;                      // Word accepted
   wire        buf_pop;                       // Word taken by shifter

   // Shifter state
   reg  [15:0] shreg;                         // Output shift register
   reg         mst_busy;                      // Master frame running
   reg  [2:0]  mst_phase;                     // Position in serial period
   reg  [4:0]  bit_cnt;                       // Periods sent in the frame
   reg  [1:0]  sck_sync;                      // Clock pin synchroniser
   reg  [1:0]  cs_sync;                       // Select synchroniser
   reg  [1:0]  chain_sync;                    // Chain input synchroniser
   reg         sck_last;                      // Previous synced clock
   reg         cs_last;                       // Previous synced select

   // Address phase and data phase decode
   wire addr_take  = hsel & htrans[1] & hready;
   wire push_wait  = dp_write & (dp_addr == `ASRP_RESULT_OFS);
   assign buf_push = push_wait & hreadyout;

   // Format the stored word: low select gives two's complement
   function [15:0] fmt;
      input [15:0] raw;
      input        ob;
      begin
         fmt = ob ? raw : {~raw[15], raw[14:0]};
      end
   endfunction

   // Edge events last one system cycle each
   // Active edge picked by the edge invert bit
   // Synchronised pins and edge events in slave mode
   wire sck_rise  = sck_sync[1] & ~sck_last;
   wire sck_fall  = ~sck_sync[1] & sck_last;
   wire sck_act   = clock_edge_invert ? sck_fall : sck_rise;
   wire cs_on     = ~cs_sync[1];
   wire cs_begin  = cs_on & cs_last;

   // Low select waits for conversion end before sending
   // High select sends at conversion start, overlapping it
   // Master frame start: timing select only consulted here
   wire mst_start = master_mode & ~mst_busy & buf_valid &
                    (read_timing_select ? conv_start : ~converting);
   wire slv_load  = slave_mode & cs_begin;
   assign buf_pop = mst_start | (slv_load & buf_valid);

   // Looks one edge ahead so a stall starts in time
   // Never passes two, the wait state blocks a third push
   // Level of the buffer after this edge, for the wait state
   reg  [1:0] next_cnt;
   always @* begin
      next_cnt = buf_cnt;
      if (buf_push & ~buf_pop) begin
         next_cnt = buf_cnt + 2'h1;
      end else if (buf_pop & ~buf_push) begin
         next_cnt = buf_cnt - 2'h1;
      end
   end

   // Writes land at the edge that ends their data phase
   // Wait state only for result writes meeting a full buffer
   // Response stays OKAY, errors are never signalled
   // Bus slave: address capture, writes, wait state on a full buffer
   always @(posedge clock) begin
      if (!rst_b) begin
         dp_write    <= 1'b0;
         dp_addr     <= 8'h00;
         hreadyout   <= 1'b1;
         hresp       <= 1'b0;
         hrdata      <= 32'h0000_0000;
         ctrl        <= `ASRP_CTRL_RESET;
         held_result <= `ASRP_RESULT_RESET;
         converting  <= 1'b0;
         conv_start  <= 1'b0;
      end else begin
         hresp      <= 1'b0;
         conv_start <= 1'b0;
         // Data phase writes complete on the ready edge
         if (dp_write & hreadyout) begin
            case (dp_addr)
               `ASRP_CTRL_OFS: begin
                  ctrl <= hwdata[`ASRP_CTRL_WIDTH-1:0];
               end
               `ASRP_RESULT_OFS: begin            // Conversion complete
                  held_result <= hwdata[15:0];
                  converting  <= 1'b0;
               end
               `ASRP_CONV_OFS: begin              // Conversion start
                  if (hwdata[0]) begin
                     converting <= 1'b1;
                     conv_start <= 1'b1;
                  end
               end
               default: begin                     // Unmapped or read-only
               end
            endcase
         end
         // Next address phase
         if (hreadyout) begin
            dp_write <= addr_take & hwrite;
            dp_addr  <= addr_take ? haddr[7:0] : 8'h00;
            if (addr_take & ~hwrite) begin
               case (haddr[7:0])
                  `ASRP_CTRL_OFS:   hrdata <= {26'h000_0000, ctrl};
                  `ASRP_RESULT_OFS: hrdata <= {16'h0000, held_result};
                  `ASRP_STATUS_OFS: hrdata <= {27'h000_0000, buf_cnt,
                                               mst_busy, converting, buf_full};
                  default:          hrdata <= 32'h0000_0000;
               endcase
            end
         end
         // Stall a result write while the buffer is full
         if (hreadyout) begin
            hreadyout <= ~(addr_take & hwrite &
                           (haddr[7:0] == `ASRP_RESULT_OFS) & (next_cnt == 2'h2));
         end else begin
            hreadyout <= ~(push_wait & (next_cnt == 2'h2));
         end
      end
   end

   // Push from the bus side, pop from the shifter side
   // Both in one cycle leave the level unchanged
   // Memory needs no reset: level gates every read
   // Two-entry buffer between bus writes and the shifter
   always @(posedge clock) begin
      if (!rst_b) begin
         buf_wr  <= 1'b0;
         buf_rd  <= 1'b0;
         buf_cnt <= 2'h0;
      end else begin
         if (buf_push) begin
            buf_mem[buf_wr] <= hwdata[15:0];
            buf_wr          <= ~buf_wr;
         end
         if (buf_pop) begin
            buf_rd <= ~buf_rd;
         end
         buf_cnt <= next_cnt;
      end
   end

   // Only the second stage feeds logic, first stage may ring
   // Select resets high to match its idle level
   // Edge history follows the second stage, one cycle late
   // Two-flop synchronisers for the pins from outside
   always @(posedge clock) begin
      if (!rst_b) begin
         sck_sync   <= 2'b00;
         cs_sync    <= 2'b11;
         chain_sync <= 2'b00;
         sck_last   <= 1'b0;
         cs_last    <= 1'b1;                  // Idle high, no false start
      end else begin
         sck_sync   <= {sck_sync[0], serial_data_clock_in};
         cs_sync    <= {cs_sync[0], chip_select_b};
         chain_sync <= {chain_sync[0], chain_serial_input};
         sck_last   <= sck_sync[1];
         cs_last    <= cs_sync[1];
      end
   end

   // Master frame has priority over any slave activity
   // Master shifts at the last phase of every period
   // Slave shifts on each active host edge while selected
   // Chain input fills in behind the own word
   // Shifter: master timing generator and slave edge follower
   always @(posedge clock) begin
      if (!rst_b) begin
         shreg     <= 16'h0000;
         mst_busy  <= 1'b0;
         mst_phase <= 3'h0;
         bit_cnt   <= 5'h00;
      end else if (mst_start) begin
         shreg     <= fmt(buf_mem[buf_rd], output_format_select);
         mst_busy  <= 1'b1;
         mst_phase <= 3'h0;
         bit_cnt   <= 5'h00;
      end else if (mst_busy) begin
         mst_phase <= mst_phase + 3'h1;
         // Bit changes one cycle after the falling edge
         if (mst_phase == `ASRP_PHASE_LAST) begin
            shreg   <= {shreg[14:0], 1'b0};
            bit_cnt <= bit_cnt + 5'h01;
            if (bit_cnt == `ASRP_BIT_LAST) begin
               mst_busy <= 1'b0;
            end
         end
      end else if (slv_load) begin
         // Fresh word if queued, else the held one again
         shreg   <= buf_valid ? fmt(buf_mem[buf_rd], output_format_select)
                              : fmt(held_result, output_format_select);
         bit_cnt <= 5'h00;
      end else if (slave_mode & cs_on & sck_act) begin
         // Chain bit enters behind the own word
         shreg <= {shreg[14:0], chain_sync[1]};
         if (bit_cnt != `ASRP_BIT_FULL) begin
            bit_cnt <= bit_cnt + 5'h01;
         end
      end
   end

   // Formatted held word for the parallel bits
   wire [15:0] par_word = fmt(held_result, output_format_select);

   // All pins registered, so they move one cycle after state
   // Device drives the clock pin except in slave mode
   // Slave mode parks clock and sync drive levels low
   // Pin drivers: serial functions or parallel bits 8 to 10
   always @(posedge clock) begin
      if (!rst_b) begin
         serial_result_out      <= 1'b0;
         serial_data_clock_out  <= 1'b0;
         serial_data_clock_oe_b <= 1'b0;
         frame_sync_out         <= 1'b0;
      end else if (!serial_parallel_select) begin
         // Parallel bus bits on the shared pins
         serial_result_out      <= par_word[8];
         serial_data_clock_out  <= par_word[9];
         serial_data_clock_oe_b <= 1'b0;
         frame_sync_out         <= par_word[10];
      end else if (master_mode) begin
         serial_result_out      <= shreg[15];
         serial_data_clock_out  <= clock_edge_invert ^ (mst_busy &
                                   (mst_phase >= `ASRP_SCLK_RISE) &
                                   (mst_phase < `ASRP_SCLK_FALL));
         serial_data_clock_oe_b <= 1'b0;
         frame_sync_out         <= frame_polarity_invert ^ mst_busy;
      end else begin
         serial_result_out      <= shreg[15];
         serial_data_clock_out  <= 1'b0;
         serial_data_clock_oe_b <= 1'b1;
         frame_sync_out         <= 1'b0;
      end
   end

endmodule // asrp_serial_result_port

// ===== asrp_chk_sva.sv
// Pin checker for the serial result port
`timescale 1ns/100ps
`include "asrp_consts.vh"
module asrp_chk (
   input wire        clock,                 // Clock
   input wire        rst_b,                 // Reset
   input wire        hsel,                  // Select
   input wire [31:0] haddr,                 // Address
   input wire [1:0]  htrans,                // Transfer
   input wire        hwrite,                // Write
   input wire [31:0] hwdata,                // Wdata
   input wire        hreadyout,             // Ready
   input wire        serial_result_out,     // Data pin
   input wire        serial_data_clock_out, // Clock pin
   input wire        serial_data_clock_oe_b,// Clock enable
   input wire        frame_sync_out         // Sync pin
);
   reg  [7:0] a_q;    // Data phase address
   reg        w_q;    // Write in data phase
   reg  [5:0] ctrl;   // Snooped control
   reg  [5:0] ctrl_d; // Control as pins see it
   reg  [7:0] cnt;    // Frame length so far
   reg  [4:0] rises;  // Clock rises in frame
   reg        clk_q;  // Last clock pin
   wire       master = ctrl_d[0] & ~ctrl_d[1];  // Serial master
   wire       slave  = ctrl_d[0] & ctrl_d[1];   // Serial slave
   wire       act    = frame_sync_out ^ ctrl_d[4]; // Frame active
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_b);
   // Snoop control writes, measure frames
   always @(posedge clock) begin
      if (!rst_b) begin
         w_q <= 1'b0;
         a_q <= 8'h00;
         ctrl <= 6'h00;
         ctrl_d <= 6'h00;
         cnt <= 8'h00;
         rises <= 5'h00;
         clk_q <= 1'b0;
      end else begin
         if (hreadyout) begin
            w_q <= hsel & htrans[1] & hwrite;
            a_q <= haddr[7:0];
         end
         if (w_q && hreadyout && a_q == `ASRP_CTRL_OFS)
            ctrl <= hwdata[5:0];
         ctrl_d <= ctrl;
         cnt <= act ? cnt + 8'h01 : 8'h00;
         rises <= act ? rises + {4'h0, serial_data_clock_out & ~clk_q} : 5'h00;
         clk_q <= serial_data_clock_out;
      end
   end
   AST_SLAVE_OE: assert property (slave |-> serial_data_clock_oe_b)
      else $error("clock pin driven in slave mode");
   AST_DRIVE_OE: assert property (!slave |-> !serial_data_clock_oe_b)
      else $error("clock pin not driven");
   AST_SLAVE_QUIET: assert property (slave |-> !serial_data_clock_out && !frame_sync_out)
      else $error("slave mode drives clock or sync");
   AST_MASTER_HOLD: assert property (master && $stable(ctrl_d) && $changed(serial_data_clock_out)
      |-> $stable(serial_result_out) ##1 $stable(serial_result_out))
      else $error("data moved at a clock edge");
   AST_CLK_HIGH: assert property (master && $stable(ctrl_d) && act && $rose(serial_data_clock_out)
      |=> (serial_data_clock_out || !act)[*3])
      else $error("clock high phase too short");
   AST_FRAME_LEN: assert property (master && $stable(ctrl_d) && $fell(act) |-> cnt == 8'h80)
      else $error("sync length wrong");
   AST_FRAME_RISES: assert property (master && !ctrl_d[3] && $stable(ctrl_d) && $fell(act)
      |-> rises == 5'h10)
      else $error("frame clock count wrong");
   AST_SYNC_ACTIVE: assert property (master && !ctrl_d[3] && $stable(ctrl_d)
      && $rose(serial_data_clock_out) |-> act)
      else $error("clock outside frame sync");
   cover property (master && $fell(act));
   cover property (slave && $fell(serial_result_out));
   cover property (!ctrl_d[0] && $changed(frame_sync_out));
endmodule // asrp_chk
bind asrp_serial_result_port asrp_chk asrp_chk_inst (.clock(clock), .rst_b(rst_b), .hsel(hsel),
   .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hreadyout(hreadyout),
   .serial_result_out(serial_result_out), .serial_data_clock_out(serial_data_clock_out),
   .serial_data_clock_oe_b(serial_data_clock_oe_b), .frame_sync_out(frame_sync_out));

// ===== asrp_host_model.sv
// Host side of the serial link
`timescale 1ns/100ps
module asrp_host_model (
   input  wire        start,        // Slave frame request
   input  wire        edge_inv,     // Active edge is falling
   input  wire [15:0] chain_word,   // Chained word
   input  wire        sdo,          // Device data pin
   input  wire        sclk_o,       // Device clock pin
   output reg         sclk,         // Host clock
   output reg         cs_b,         // Frame gate, low
   output reg         chain_bit,    // Chain input
   output reg  [31:0] cap,          // Slave capture
   output reg         done,         // Slave frame over
   output reg  [15:0] mcap          // Master capture
);
   initial {sclk, cs_b, chain_bit, cap, done, mcap} = {3'h2, 32'h0, 1'b0, 16'h0};
   // Master capture on rising pin edge
   always @(posedge sclk_o) mcap <= {mcap[14:0], sdo};
   // Slave frame, clock still outside it, 125 ns period
   always @(posedge start) begin : frame
      integer i;
      done = 1'b0;
      sclk = edge_inv;
      #3.3 cs_b = 1'b0;
      #62.5;
      for (i = 0; i < 32; i = i + 1) begin
         #31 cap[31-i] = sdo;
         chain_bit = (i < 16) ? chain_word[15-i] : ~chain_bit;
         #31.5 sclk = ~edge_inv;
         #62.5 sclk = edge_inv;
      end
      #62.5 cs_b = 1'b1;
      chain_bit = ~chain_bit;  // Released line moves
      done = 1'b1;
   end
endmodule // asrp_host_model

// ===== tb_top.sv
// Testbench for the serial result port
`timescale 1ns/100ps
`include "asrp_consts.vh"
module tb_top;
   reg         clock = 1'b0;          // Clock
   reg         rst_b = 1'b0;          // Reset
   reg         hsel = 1'b0;           // Select
   reg  [31:0] haddr = 32'h0000_0000; // Address
   reg  [1:0]  htrans = 2'h0;         // Transfer
   reg         hwrite = 1'b0;         // Write
   reg  [31:0] hwdata = 32'h0000_0000;// Write data
   reg         start = 1'b0;          // Slave frame kick
   reg         edge_inv = 1'b0;       // Host edge sense
   reg  [15:0] chain_word = 16'h0000; // Chain data
   wire        hreadyout, hresp, sdo, sclk_o, oe_b, fso, sclk_i, cs_b, chain_bit, done;
   wire [31:0] hrdata, cap;           // Read data, capture
   wire [15:0] mcap;                  // Master capture
   integer     failures = 0, cmp_count = 0, cyc = 0, k;
   reg  [31:0] seed = 78240, q;       // Random state, read data
   reg  [15:0] r, que[$];             // Last raw word, expected words
   always #2.5 clock = ~clock;
   function [31:0] rnd(input d);
      begin
         seed = seed ^ (seed << 13);
         seed = seed ^ (seed >> 17);
         seed = seed ^ (seed << 5);
         rnd = seed;
      end
   endfunction
   task chk(input [31:0] seen, input [31:0] exp);
      begin
         cmp_count = cmp_count + 1;
         if (seen !== exp) begin
            failures = failures + 1;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
         end
      end
   endtask
   // One single bus transfer
   task bus(input w, input [31:0] a, input [31:0] d);
      begin
         {hsel, haddr, hwrite, htrans} <= {1'b1, a, w, 2'h2};
         @(posedge clock);
         while (hreadyout !== 1'b1) @(posedge clock);
         {hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
         @(posedge clock);
         while (hreadyout !== 1'b1) @(posedge clock);
         q = hrdata;
      end
   endtask
   task push(input ob);
      begin
         r = rnd(0);
         que.push_back(ob ? r : r ^ 16'h8000);
         bus(1, `ASRP_RESULT_OFS, {16'h0000, r});
      end
   endtask
   task wait_frame;
      begin
         bus(0, `ASRP_STATUS_OFS, 0);
         while (!q[2]) bus(0, `ASRP_STATUS_OFS, 0);
         while (q[2]) bus(0, `ASRP_STATUS_OFS, 0);
         chk(mcap, que.pop_front());
      end
   endtask
   task print_verdict;
      begin
         if (failures == 0 && cmp_count > 0) $display("TB: PASS");
         else $display("TB: FAIL");
         $finish;
      end
   endtask
   // Hang guard
   always @(posedge clock) begin
      cyc = cyc + 1;
      if (cyc == 20000) begin
         failures = failures + 1;
         print_verdict;
      end
   end
   initial begin
      repeat (5) @(posedge clock);
      rst_b <= 1'b1;
      @(posedge clock);
      for (k = 0; k < 4; k = k + 1) begin
         bus(1, `ASRP_CTRL_OFS, 32'h1 | (k << 3) | (k[0] << 5));
         push(k[0]);
         wait_frame;
         chk(fso, k[1]);
      end
      bus(1, `ASRP_CTRL_OFS, 32'h25);
      push(1);
      push(1);
      bus(0, `ASRP_STATUS_OFS, 0);
      chk(q, 32'h11);
      repeat (2) begin
         bus(1, `ASRP_CONV_OFS, 1);
         bus(0, `ASRP_STATUS_OFS, 0);
         bus(0, `ASRP_STATUS_OFS, 0);
         chk(q[2:1], 2'h3);
         wait_frame;
      end
      for (k = 0; k < 2; k = k + 1) begin
         bus(1, `ASRP_CTRL_OFS, 32'h23 | (k << 3));
         push(1);
         q = rnd(0);
         {edge_inv, chain_word, start} <= {k[0], q[15:0], 1'b1};
         @(posedge clock);
         start <= 1'b0;
         while (done !== 1'b1) @(posedge clock);
         chk(cap, {que.pop_front(), chain_word});
         chk({oe_b, sclk_o, fso}, 3'h4);
         bus(0, `ASRP_RESULT_OFS, 0);
         chk(q, r);
      end
      bus(1, `ASRP_CTRL_OFS, 0);
      bus(0, `ASRP_STATUS_OFS, 0);
      chk(q, 0);
      chk({fso, sclk_o, sdo}, r[10:8]);
      bus(1, 32'h10, 32'hffff_ffff);
      bus(0, 32'h10, 0);
      chk({hresp, q}, 0);
      print_verdict;
   end
   asrp_serial_result_port asrp_serial_result_port_inst (.clock(clock), .rst_b(rst_b),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
      .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
      .hresp(hresp), .serial_data_clock_in(sclk_i), .chip_select_b(cs_b),
      .chain_serial_input(chain_bit), .serial_result_out(sdo),
      .serial_data_clock_out(sclk_o), .serial_data_clock_oe_b(oe_b), .frame_sync_out(fso));
   asrp_host_model asrp_host_model_inst (.start(start), .edge_inv(edge_inv),
      .chain_word(chain_word), .sdo(sdo), .sclk_o(sclk_o), .sclk(sclk_i), .cs_b(cs_b),
      .chain_bit(chain_bit), .cap(cap), .done(done), .mcap(mcap));
endmodule // tb_top
